// file: rtl/level_interrupt_priority_ctrl.v
`timescale 1ns/100ps
`include "level_irq_consts.vh"

// Function
// - Lower priority number means more urgent; zero wins.
// - Within one level the source with lower vector address wins, fixed.
// - Enable instruction sets global enable bit 0; disable instruction clears it.
// - Software may also write the global enable bit directly.
// - Level mask bit n gates level n; 0 masks, 1 allows.
// - Mask contents undefined after reset; software writes it before enabling.
// - Levels grouped: A is 0-1, B is 2-4, C is 5-7.
// - Priority bits 7,4,1 order groups; 001 is B>C>A, 101 is C>B>A.
// - Bit 6 orders subgroup 6/7; bit 5 orders level 5 against subgroup.
// - Bit 3 orders subgroup 3/4; bit 2 orders level 2 against subgroup.
// - Priority bit 0 decides between level 0 and level 1.
// - Priority register undefined after reset; software programs it first.
// - Highest effective priority among enabled active requests is presented first.
// - Service needs global enable, unmasked level and source enabled.
// - Level request register is read-only, one pending flag per level.
// - Reset clears system mode bits 7, 1, 0; fast level select undefined.
// - System mode holds global enable and fast interrupt enable.
// - Ten sources map onto levels 0 to 7 as fixed wiring.
// - Request bits are zero after reset, one while a level requests.
// - Request bits keep tracking while globally disabled.
// - Acknowledge clears global enable; return instruction sets it again.
module level_interrupt_priority_ctrl
#(
  parameter NUM_SOURCES = 10,
  parameter NUM_LEVELS = 8
)
(
  input wire clk,
  input wire sys_rst,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  output reg reg_hit,
  input wire enable_interrupts_instruction,
  input wire disable_interrupts_instruction,
  input wire interrupt_return_instruction,
  input wire int_ack,
  input wire [NUM_SOURCES-1:0] src_req,
  output wire int_req,
  output reg [2:0] int_level,
  output reg [3:0] int_source,
  output reg int_fast
);

  // ------------------------------------------------------------
  // Presentation states
  // ------------------------------------------------------------
  localparam ST_IDLE = 2'b01;
  localparam ST_PRESENT = 2'b10;

  reg [7:0] system_mode_q;
  reg [7:0] level_mask_q;
  reg [7:0] level_priority_q;
  reg [7:0] level_request_q;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [7:0] level_request_d;
  reg [7:0] eligible;
  reg win_found;
  reg [2:0] win_level;
  reg [3:0] win_key;
  reg [3:0] key_n;
  integer i;

  // ------------------------------------------------------------
  // Priority key of one level, smaller is more urgent
  // ------------------------------------------------------------
  // Key is group position times four plus rank inside the group, so
  // no two levels ever share a key and a plain minimum search works.
  function [3:0] level_key;
    input [7:0] pri;
    input [2:0] lvl;
    reg [2:0] code;
    reg [1:0] pos_a;
    reg [1:0] pos_b;
    reg [1:0] pos_c;
    reg [1:0] pos;
    reg [1:0] rank;
    begin
      code = {pri[`PRI_GRP_ORD_HI_BIT], pri[`PRI_GRP_ORD_MID_BIT], pri[`PRI_GRP_ORD_LO_BIT]};
      // Codes 000 and 111 carry no defined order; treat them as A>B>C
      case (code)
        `GRP_B_C_A:
        begin
          pos_a = 2'h2;
          pos_b = 2'h0;
          pos_c = 2'h1;
        end
        `GRP_B_A_C:
        begin
          pos_a = 2'h1;
          pos_b = 2'h0;
          pos_c = 2'h2;
        end
        `GRP_C_A_B:
        begin
          pos_a = 2'h1;
          pos_b = 2'h2;
          pos_c = 2'h0;
        end
        `GRP_C_B_A:
        begin
          pos_a = 2'h2;
          pos_b = 2'h1;
          pos_c = 2'h0;
        end
        `GRP_A_C_B:
        begin
          pos_a = 2'h0;
          pos_b = 2'h2;
          pos_c = 2'h1;
        end
        default:
        begin
          pos_a = 2'h0;
          pos_b = 2'h1;
          pos_c = 2'h2;
        end
      endcase
      // Rank inside each group
      case (lvl)
        3'h0:
        begin
          pos = pos_a;
          rank = pri[`PRI_A_ORDER_BIT] ? 2'h1 : 2'h0;
        end
        3'h1:
        begin
          pos = pos_a;
          rank = pri[`PRI_A_ORDER_BIT] ? 2'h0 : 2'h1;
        end
        3'h2:
        begin
          pos = pos_b;
          rank = pri[`PRI_B_SPLIT_BIT] ? 2'h2 : 2'h0;
        end
        3'h3:
        begin
          pos = pos_b;
          rank = (pri[`PRI_B_SPLIT_BIT] ? 2'h0 : 2'h1) + (pri[`PRI_B_SUB_BIT] ? 2'h1 : 2'h0);
        end
        3'h4:
        begin
          pos = pos_b;
          rank = (pri[`PRI_B_SPLIT_BIT] ? 2'h0 : 2'h1) + (pri[`PRI_B_SUB_BIT] ? 2'h0 : 2'h1);
        end
        3'h5:
        begin
          pos = pos_c;
          rank = pri[`PRI_C_SPLIT_BIT] ? 2'h2 : 2'h0;
        end
        3'h6:
        begin
          pos = pos_c;
          rank = (pri[`PRI_C_SPLIT_BIT] ? 2'h0 : 2'h1) + (pri[`PRI_C_SUB_BIT] ? 2'h1 : 2'h0);
        end
        default:
        begin
          pos = pos_c;
          rank = (pri[`PRI_C_SPLIT_BIT] ? 2'h0 : 2'h1) + (pri[`PRI_C_SUB_BIT] ? 2'h0 : 2'h1);
        end
      endcase
      level_key = {pos, rank};
    end
  endfunction

  // ------------------------------------------------------------
  // First requesting source of a level, lower vector first
  // ------------------------------------------------------------
  function [3:0] level_source;
    input [2:0] lvl;
    input [9:0] req;
    begin
      case (lvl)
        3'h0: level_source = req[0] ? 4'h0 : 4'h1;
        3'h1: level_source = 4'h2;
        3'h2: level_source = req[3] ? 4'h3 : 4'h4;
        3'h3: level_source = 4'h5;
        3'h4: level_source = 4'h6;
        3'h5: level_source = 4'h7;
        3'h6: level_source = 4'h8;
        default: level_source = 4'h9;
      endcase
    end
  endfunction

  // ------------------------------------------------------------
  // Source to level wiring
  // ------------------------------------------------------------
  // Sources arrive already gated by their own peripheral enable, so a
  // disabled source never reaches the request flags.
  always @*
  begin
    level_request_d = {src_req[9], src_req[8], src_req[7], src_req[6], src_req[5],
                       src_req[4] | src_req[3], src_req[2], src_req[1] | src_req[0]};
  end

  // ------------------------------------------------------------
  // Winner search over eligible levels
  // ------------------------------------------------------------
  always @*
  begin
    eligible = level_request_q & level_mask_q &
               {NUM_LEVELS{system_mode_q[`MODE_GLOBAL_EN_BIT]}};
    win_found = 1'b0;
    win_level = 3'h0;
    win_key = 4'hF;
    key_n = 4'hF;
    for (i = 0; i < NUM_LEVELS; i = i + 1)
    begin
      key_n = level_key(level_priority_q, i[2:0]);
      if (eligible[i] && (!win_found || key_n < win_key))
      begin
        win_found = 1'b1;
        win_level = i[2:0];
        win_key = key_n;
      end
    end
  end

  // ------------------------------------------------------------
  // Presentation state machine
  // ------------------------------------------------------------
  // A held level is dropped if it stops being eligible, so a disable
  // or mask write never leaves a stale request in front of the core.
  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
        if (win_found)
          state_d = ST_PRESENT;
      ST_PRESENT:
        if (int_ack || !eligible[int_level])
          state_d = ST_IDLE;
      default:
        state_d = ST_IDLE;
    endcase
  end

  assign int_req = state_q[1];

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_q <= ST_IDLE;
      int_level <= 3'h0;
      int_source <= 4'h0;
      int_fast <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      // Winner latched on entry only, then frozen until acknowledged or dropped
      if (state_q == ST_IDLE && win_found)
      begin
        int_level <= win_level;
        int_source <= level_source(win_level, src_req);
        int_fast <= system_mode_q[`MODE_FAST_EN_BIT] &&
                    (system_mode_q[`MODE_FAST_SEL_MSB:`MODE_FAST_SEL_LSB] == win_level);
      end
    end
  end

  // ------------------------------------------------------------
  // Level request flags
  // ------------------------------------------------------------
  // Tracked regardless of the global enable so software can poll them.
  always @(posedge clk)
  begin
    if (sys_rst)
      level_request_q <= `RST_LEVEL_REQUEST;
    else
      level_request_q <= level_request_d;
  end

  // ------------------------------------------------------------
  // System mode register
  // ------------------------------------------------------------
  // Later statements win: acknowledge beats return and enable, which
  // beat disable, which beats a plain write of the same bit.
  always @(posedge clk)
  begin
    if (sys_rst)
      system_mode_q <= `RST_SYSTEM_MODE;
    else
    begin
      if (reg_wr && reg_addr == `ADDR_SYSTEM_MODE)
        system_mode_q <= reg_wdata;
      if (disable_interrupts_instruction)
        system_mode_q[`MODE_GLOBAL_EN_BIT] <= 1'b0;
      if (enable_interrupts_instruction || interrupt_return_instruction)
        system_mode_q[`MODE_GLOBAL_EN_BIT] <= 1'b1;
      if (int_ack && state_q == ST_PRESENT)
        system_mode_q[`MODE_GLOBAL_EN_BIT] <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Mask and priority registers
  // ------------------------------------------------------------
  // Reset value is a fixed zero; software must still program both.
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      level_mask_q <= `RST_LEVEL_MASK;
      level_priority_q <= `RST_LEVEL_PRIORITY;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `ADDR_LEVEL_MASK)
        level_mask_q <= reg_wdata;
      if (reg_addr == `ADDR_LEVEL_PRIORITY)
        level_priority_q <= reg_wdata;
    end
  end

  // ------------------------------------------------------------
  // Register read port
  // ------------------------------------------------------------
  // Writes to the request register are ignored; it is loaded only from the sources.
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      reg_rdata <= 8'h00;
      reg_hit <= 1'b0;
    end
    else
    begin
      reg_hit <= 1'b0;
      if (reg_rd)
      begin
        reg_hit <= 1'b1;
        case (reg_addr)
          `ADDR_LEVEL_REQUEST: reg_rdata <= level_request_q;
          `ADDR_LEVEL_MASK: reg_rdata <= level_mask_q;
          `ADDR_SYSTEM_MODE: reg_rdata <= system_mode_q;
          `ADDR_LEVEL_PRIORITY: reg_rdata <= level_priority_q;
          default:
          begin
            reg_rdata <= 8'h00;
            reg_hit <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule

// file: include/level_irq_consts.vh
`ifndef LEVEL_IRQ_CONSTS_VH
`define LEVEL_IRQ_CONSTS_VH

// ------------------------------------------------------------
// Register addresses in the core register space
// ------------------------------------------------------------
`define ADDR_LEVEL_REQUEST 8'hDC
`define ADDR_LEVEL_MASK 8'hDD
`define ADDR_SYSTEM_MODE 8'hDE
`define ADDR_LEVEL_PRIORITY 8'hFF

// ------------------------------------------------------------
// System mode register fields
// ------------------------------------------------------------
`define MODE_GLOBAL_EN_BIT 0
`define MODE_FAST_EN_BIT 1
`define MODE_FAST_SEL_LSB 2
`define MODE_FAST_SEL_MSB 4
`define MODE_EXT_IF_BIT 7

// ------------------------------------------------------------
// Level priority register fields
// ------------------------------------------------------------
`define PRI_A_ORDER_BIT 0
`define PRI_GRP_ORD_LO_BIT 1
`define PRI_B_SPLIT_BIT 2
`define PRI_B_SUB_BIT 3
`define PRI_GRP_ORD_MID_BIT 4
`define PRI_C_SPLIT_BIT 5
`define PRI_C_SUB_BIT 6
`define PRI_GRP_ORD_HI_BIT 7

// Group order codes (bits 7,4,1)
`define GRP_B_C_A 3'h1
`define GRP_A_B_C 3'h2
`define GRP_B_A_C 3'h3
`define GRP_C_A_B 3'h4
`define GRP_C_B_A 3'h5
`define GRP_A_C_B 3'h6

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define RST_SYSTEM_MODE 8'h00
`define RST_LEVEL_MASK 8'h00
`define RST_LEVEL_PRIORITY 8'h00
`define RST_LEVEL_REQUEST 8'h00

`endif

// file: testbench/irq_ctrl_chk.sv
`timescale 1ns/100ps
`include "level_irq_consts.vh"
// ------------------------------------------
// Port checker
// ------------------------------------------
module irq_ctrl_chk
#(
  parameter NUM_SOURCES = 10,
  parameter NUM_LEVELS = 8
)
(
  input wire clk,
  input wire sys_rst,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire reg_hit,
  input wire enable_interrupts_instruction,
  input wire disable_interrupts_instruction,
  input wire interrupt_return_instruction,
  input wire int_ack,
  input wire [NUM_SOURCES-1:0] src_req,
  input wire int_req,
  input wire [2:0] int_level,
  input wire [3:0] int_source
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire mapped = reg_addr == `ADDR_LEVEL_REQUEST || reg_addr == `ADDR_LEVEL_MASK ||
                reg_addr == `ADDR_SYSTEM_MODE || reg_addr == `ADDR_LEVEL_PRIORITY;
  wire no_set = !enable_interrupts_instruction && !interrupt_return_instruction &&
                !(reg_wr && reg_addr == `ADDR_SYSTEM_MODE);
  // Fixed wiring of source index to level
  function automatic [2:0] lvl_of(input [3:0] s);
    lvl_of = (s < 4'h2) ? 3'h0 : (s == 4'h2) ? 3'h1 : (s < 4'h5) ? 3'h2 : s[2:0] - 3'h2;
  endfunction
  sequence s_present;
    $rose(int_req);
  endsequence
  // Global enable clearing drops the request line two cycles after the disable; three quiet cycles are checked
  sequence s_di_quiet;
    (disable_interrupts_instruction && no_set) ##1 no_set[*3];
  endsequence
  AST_HIT: assert property (reg_rd && mapped |=> reg_hit) else $error("no hit on mapped read");
  AST_UNMAP: assert property (reg_rd && !mapped |=> !reg_hit && reg_rdata == 8'h00)
    else $error("unmapped read answered");
  AST_HIT_CAUSE: assert property (reg_hit |-> $past(reg_rd)) else $error("hit without read");
  AST_CAUSE: assert property (s_present |-> ((($past(src_req, 2)) >> int_source) & 1) != 0)
    else $error("presented source was not requesting");
  AST_MAP: assert property (s_present |-> int_level == lvl_of(int_source))
    else $error("source and level disagree");
  AST_ORDER: assert property (s_present ##0 (int_level == 3'h0 && $past(src_req[0], 2)) |-> int_source == 4'h0)
    else $error("wrong source inside level");
  AST_ACK: assert property (int_req && int_ack |=> !int_req) else $error("request kept after ack");
  AST_HOLD: assert property (int_req && $past(int_req) |-> $stable(int_level) && $stable(int_source))
    else $error("presented level moved");
  AST_DI: assert property (s_di_quiet |-> !int_req) else $error("request while disabled");
endmodule
bind level_interrupt_priority_ctrl irq_ctrl_chk #(.NUM_SOURCES(NUM_SOURCES), .NUM_LEVELS(NUM_LEVELS)) u_chk (
  .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .reg_hit(reg_hit), .enable_interrupts_instruction(enable_interrupts_instruction),
  .disable_interrupts_instruction(disable_interrupts_instruction),
  .interrupt_return_instruction(interrupt_return_instruction), .int_ack(int_ack), .src_req(src_req),
  .int_req(int_req), .int_level(int_level), .int_source(int_source));

// file: testbench/core_ack_model.sv
`timescale 1ns/100ps
// ------------------------------------------
// Core side: acknowledges a presented level
// ------------------------------------------
module core_ack_model
(
  input wire clk,
  input wire sys_rst,
  input wire int_req,
  input wire [3:0] ack_wait,
  output reg int_ack
);
  reg [3:0] wait_q;
  // Ack only after ack_wait boundaries; one-cycle pulse so it never counts twice
  always @(posedge clk)
  begin
    if (sys_rst || !int_req || int_ack)
    begin
      wait_q <= 4'h0;
      int_ack <= 1'b0;
    end
    else if (wait_q == ack_wait)
      int_ack <= 1'b1;
    else
      wait_q <= wait_q + 4'h1;
  end
endmodule

// file: testbench/level_interrupt_priority_ctrl_tb.sv
`timescale 1ns/100ps
`include "level_irq_consts.vh"
module level_interrupt_priority_ctrl_tb;
  reg clk = 1'b0;
  reg sys_rst = 1'b1;
  reg [7:0] reg_addr = 8'h00;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg [7:0] reg_wdata = 8'h00;
  reg [2:0] ins = 3'h0;
  reg [9:0] src_req = 10'h000;
  reg [3:0] ack_wait = 4'hF;
  reg [7:0] v;
  wire [7:0] reg_rdata;
  wire reg_hit, int_ack, int_req, int_fast;
  wire [2:0] int_level;
  wire [3:0] int_source;
  integer errors = 0;
  integer checks_done = 0;
  integer cycles = 0;
  // ------------------------------------------
  // Clock, design and core model
  // ------------------------------------------
  always #12.5 clk = ~clk;
  level_interrupt_priority_ctrl DUT (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
    .enable_interrupts_instruction(ins[0]), .disable_interrupts_instruction(ins[1]),
    .interrupt_return_instruction(ins[2]), .int_ack(int_ack), .src_req(src_req), .int_req(int_req),
    .int_level(int_level), .int_source(int_source), .int_fast(int_fast));
  core_ack_model core (.clk(clk), .sys_rst(sys_rst), .int_req(int_req), .ack_wait(ack_wait), .int_ack(int_ack));
  // Hang guard: well above the few hundred cycles the sequence needs
  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      errors = errors + 1;
      give_verdict;
    end
  end
  // ------------------------------------------
  // Access tasks
  // ------------------------------------------
  task give_verdict;
    begin
      if (errors == 0 && checks_done > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task chk(input string what, input [7:0] seen, input [7:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp)
      begin
        errors = errors + 1;
        $display("BAD %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
    end
  endtask
  // Data and hit are registered, so both are looked at just after the next edge
  task rd(input [7:0] a, input hit_exp);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk("hit", {7'h00, reg_hit}, {7'h00, hit_exp});
      v = reg_rdata;
    end
  endtask
  task pulse(input [2:0] m);
    begin
      @(posedge clk);
      ins <= m;
      @(posedge clk);
      ins <= 3'h0;
    end
  endtask
  task wait_req(input b);
    integer n;
    begin
      n = 0;
      #1;
      while (int_req !== b && n < 20)
      begin
        @(posedge clk);
        #1;
        n = n + 1;
      end
      chk("int_req", {7'h00, int_req}, {7'h00, b});
    end
  endtask
  // Sources settle first so the winner is chosen among all of them at once
  task run_case(input [7:0] pri, input [7:0] msk, input [9:0] src, input [7:0] system_mode, input [2:0] lvl,
    input [3:0] s, input f);
    begin
      ack_wait <= {1'b0, lvl} + 4'h1;
      wr(`ADDR_LEVEL_PRIORITY, pri);
      wr(`ADDR_LEVEL_MASK, msk);
      @(posedge clk);
      src_req <= src;
      repeat (3) @(posedge clk);
      if (system_mode == 8'h00)
        pulse(3'h1);
      else if (system_mode == 8'h01)
        pulse(3'h4);
      else
        wr(`ADDR_SYSTEM_MODE, system_mode);
      wait_req(1'b1);
      chk("level", {5'h00, int_level}, {5'h00, lvl});
      chk("source", {4'h0, int_source}, {4'h0, s});
      chk("fast", {7'h00, int_fast}, {7'h00, f});
      wait_req(1'b0);
      @(posedge clk);
      src_req <= 10'h000;
      rd(`ADDR_SYSTEM_MODE, 1'b1);
      chk("global", v & 8'h01, 8'h00);
    end
  endtask
  // ------------------------------------------
  // Test sequence
  // ------------------------------------------
  initial
  begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    rd(`ADDR_SYSTEM_MODE, 1'b1);
    chk("mode reset", v & 8'h83, 8'h00);
    rd(`ADDR_LEVEL_REQUEST, 1'b1);
    chk("request reset", v, 8'h00);
    rd(8'h10, 1'b0);
    chk("unmapped", v, 8'h00);
    wr(`ADDR_LEVEL_REQUEST, 8'hFF);
    rd(`ADDR_LEVEL_REQUEST, 1'b1);
    chk("request ro", v, 8'h00);
    wr(`ADDR_LEVEL_MASK, 8'h5A);
    rd(`ADDR_LEVEL_MASK, 1'b1);
    chk("mask", v, 8'h5A);
    wr(`ADDR_LEVEL_PRIORITY, 8'hA5);
    rd(`ADDR_LEVEL_PRIORITY, 1'b1);
    chk("priority", v, 8'hA5);
    // Level unmasked so the disable instruction must pull a presented request
    wr(`ADDR_LEVEL_MASK, 8'h08);
    @(posedge clk);
    src_req <= 10'h020;
    pulse(3'h1);
    pulse(3'h2);
    wr(`ADDR_LEVEL_MASK, 8'h08);
    repeat (4) @(posedge clk);
    wait_req(1'b0);
    rd(`ADDR_LEVEL_REQUEST, 1'b1);
    chk("request off", v, 8'h08);
    ack_wait <= 4'h4;
    pulse(3'h4);
    wait_req(1'b1);
    chk("level ret", {5'h00, int_level}, 8'h03);
    wait_req(1'b0);
    @(posedge clk);
    src_req <= 10'h000;
    run_case(8'h02, 8'hFF, 10'h089, 8'h00, 3'h2, 4'h3, 1'b0);
    run_case(8'h10, 8'hFF, 10'h088, 8'h00, 3'h2, 4'h3, 1'b0);
    run_case(8'h12, 8'hFF, 10'h081, 8'h01, 3'h0, 4'h0, 1'b0);
    run_case(8'h80, 8'hFF, 10'h009, 8'h00, 3'h0, 4'h0, 1'b0);
    run_case(8'h82, 8'hFF, 10'h089, 8'h00, 3'h5, 4'h7, 1'b0);
    run_case(8'h90, 8'hFF, 10'h088, 8'h00, 3'h5, 4'h7, 1'b0);
    run_case(8'h10, 8'hFF, 10'h006, 8'h00, 3'h0, 4'h1, 1'b0);
    run_case(8'h11, 8'hFF, 10'h006, 8'h01, 3'h1, 4'h2, 1'b0);
    run_case(8'h02, 8'hFF, 10'h060, 8'h00, 3'h3, 4'h5, 1'b0);
    run_case(8'h0A, 8'hFF, 10'h060, 8'h00, 3'h4, 4'h6, 1'b0);
    run_case(8'h06, 8'hFF, 10'h028, 8'h00, 3'h3, 4'h5, 1'b0);
    run_case(8'hA2, 8'hFF, 10'h180, 8'h00, 3'h6, 4'h8, 1'b0);
    run_case(8'hE2, 8'hFF, 10'h300, 8'h00, 3'h7, 4'h9, 1'b0);
    run_case(8'h10, 8'hFE, 10'h005, 8'h00, 3'h1, 4'h2, 1'b0);
    run_case(8'h02, 8'hFF, 10'h018, 8'h00, 3'h2, 4'h3, 1'b0);
    run_case(8'h10, 8'h08, 10'h020, 8'h0F, 3'h3, 4'h5, 1'b1);
    give_verdict;
  end
endmodule
